// ---- sfpi_edge.sv ----
// sfpi_edge: serial clock edge finder on synchronised pins
// assumes: sck input already passed through sfpi_sync
`timescale 1ns/10ps
`default_nettype none
module sfpi_edge (
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic sck_s,
  input  wire logic gate,
  output logic      rise,
  output logic      fall
);
  logic sck_r;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sck_r <= 1'b0;
      rise  <= 1'b0;
      fall  <= 1'b0;
    end else begin
      sck_r <= sck_s;
      rise  <= gate & sck_s & ~sck_r;
      fall  <= gate & ~sck_s & sck_r;
    end
  end
endmodule
`default_nettype wire

// ---- sfpi_host.sv ----
// sfpi_host: spi host model on the flash pins, run by bench tasks
// assumes: sck period of 8 core_clk cycles, still outside frames except in the bench's refused-input step
`timescale 1ns/10ps
`default_nettype none
module sfpi_host (
  input  wire logic       core_clk,
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_oe,
  output logic            cs_n,
  output logic            sck,
  output logic            pause_n,
  output logic      [3:0] io_in
);
  logic [3:0] drv = 4'h0, hoe = 4'h0;
  logic       cpol = 1'b0, flt = 1'b0;
  initial {cs_n, sck, pause_n} = 3'h5;
  always @(posedge core_clk) flt <= ~flt;
  // released lines: io3 pulled up, the rest toggle so no stale value survives
  always_comb
    for (int i = 0; i < 4; i++)
      io_in[i] = io_oe[i] ? io_out[i] : hoe[i] ? drv[i] : (i == 3) | flt;
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic sel(input logic m3, input logic hold);
    cpol <= m3;
    sck <= m3;
    tick(2);
    cs_n <= 1'b0;
    tick(4);
    if (hold) begin  // pause only while selected, with sck at its m3 idle level
      pause_n <= 1'b0;
      tick(4);
      sck <= 1'b1;
      tick(4);
      sck <= 1'b0;
      tick(4);
      pause_n <= 1'b1;
      tick(4);
    end
  endtask
  task automatic desel();
    sck <= cpol;
    tick(4);
    cs_n <= 1'b1;
    hoe <= 4'h0;
    tick(8);
  endtask
  task automatic xfer(input logic [7:0] tx, input int lanes, output logic [7:0] rx);
    for (int k = 0; k < 8; k += lanes) begin
      sck <= 1'b0;
      hoe <= (lanes == 1) ? 4'h1 : 4'h0;  // single-bit traffic on io0 only
      drv <= {3'h0, tx[7-k]};
      tick(4);
      sck <= 1'b1;  // input held across the rising edge
      tick(2);
      rx = (lanes == 4) ? {rx[3:0], io_in} : (lanes == 2) ? {rx[5:0], io_in[1:0]} : {rx[6:0], io_in[1]};
      tick(2);
    end
  endtask
endmodule
`default_nettype wire

// ---- sfpi_pkg.sv ----
// sfpi_pkg: constants for the serial flash pin interface
// assumes: shared by the top module and the bench
package sfpi_pkg;
  localparam int PAGE_COUNT      = 65536;
  localparam int PAGE_BYTES      = 256;
  localparam int ADDR_BITS       = 24;
  localparam int ERASE_4K_BYTES  = 4096;
  localparam int ERASE_32K_BYTES = 32768;
  localparam int ERASE_64K_BYTES = 65536;
  localparam logic [7:0] CMD_READ      = 8'h03;
  localparam logic [7:0] CMD_DUAL_READ = 8'h3B;
  localparam logic [7:0] CMD_QUAD_READ = 8'h6B;
  localparam logic [7:0] CMD_PROGRAM   = 8'h02;
  localparam logic [7:0] CMD_ERASE_4K  = 8'h20;
  localparam logic [7:0] CMD_ERASE_32K = 8'h52;
  localparam logic [7:0] CMD_ERASE_64K = 8'hD8;
  localparam logic [7:0] CMD_ERASE_ALL = 8'hC7;
  localparam int DUMMY_CYCLES = 8;
  typedef enum logic [1:0] {SFPI_LANE1, SFPI_LANE2, SFPI_LANE4} sfpi_lane_type;
  typedef enum logic [3:0] {
    SFPI_OP_NONE, SFPI_OP_READ, SFPI_OP_DREAD, SFPI_OP_QREAD, SFPI_OP_PROG,
    SFPI_OP_E4K, SFPI_OP_E32K, SFPI_OP_E64K, SFPI_OP_ECHIP
  } sfpi_op_type;
endpackage

// ---- sfpi_sva.sv ----
// sfpi_sva: port checks for sfpi_top
// assumes: bound to sfpi_top; sck half period of at least 4 core_clk cycles
`timescale 1ns/10ps
`default_nettype none
module sfpi_sva (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       cs_n,
  input wire logic       sck,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe,
  input wire logic       pause_n,
  input wire logic       busy_in,
  input wire logic       standby,
  input wire logic       active,
  input wire logic       mem_rd,
  input wire logic       mem_wr
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic fell_r;
  // a select held low through reset never sets this
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst)
      fell_r <= 1'b0;
    else if ($fell(cs_n))
      fell_r <= 1'b1;
  end
  hiz_desel_a: assert property (cs_n [*6] |-> io_oe == 4'h0)
    else $error("pins driven while deselected");
  standby_idle_a: assert property ((cs_n && !busy_in) [*6] |-> standby)
    else $error("no standby when idle");
  active_sel_a: assert property (!cs_n [*6] |-> active && !standby)
    else $error("not active when selected");
  first_edge_a: assert property (mem_rd |-> fell_r)
    else $error("fetch before select edge");
  mem_sel_a: assert property ((mem_rd || mem_wr) |-> active ##1 !(mem_rd || mem_wr))
    else $error("bad array access");
  out_hold_a: assert property ((sck && !cs_n && io_oe != 4'h0) [*4] |-> $stable(io_out))
    else $error("output moved while sck high");
  lane_set_a: assert property (io_oe inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("bad lane enable");
  pause_hiz_a: assert property (!pause_n [*6] |-> io_oe == 4'h0)
    else $error("output driven in pause");
  prog_c: cover property (mem_wr);
  quad_c: cover property (io_oe == 4'hf);
  pause_c: cover property (!pause_n && !cs_n);
endmodule
bind sfpi_top sfpi_sva u_sva (.core_clk(core_clk), .rst(rst), .cs_n(cs_n), .sck(sck), .io_out(io_out),
  .io_oe(io_oe), .pause_n(pause_n), .busy_in(busy_in), .standby(standby), .active(active),
  .mem_rd(mem_rd), .mem_wr(mem_wr));
`default_nettype wire

// ---- sfpi_sync.sv ----
// sfpi_sync: two-flop synchroniser for pin inputs
// assumes: inputs are asynchronous to core_clk
`timescale 1ns/10ps
`default_nettype none
module sfpi_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  // first stage read only by the second
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_r   <= INIT;
      sync_out <= INIT;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ---- sfpi_tb_top.sv ----
// sfpi_tb_top: self-checking bench with host and array models
// assumes: sfpi_host on the pins; the array answers the cycle after mem_rd
`timescale 1ns/10ps
`default_nettype none
module sfpi_tb_top;
  import sfpi_pkg::*;
  localparam logic [7:0] EC [4] = '{CMD_ERASE_4K, CMD_ERASE_32K, CMD_ERASE_64K, CMD_ERASE_ALL};
  logic        core_clk = 1'b0, rst = 1'b1, quad_enable_bit = 1'b0, busy_in = 1'b0;
  logic        cs_n, sck, pause_n, standby, active, wr_protect_n, mem_rd, mem_wr, erase_req;
  logic [3:0]  io_in, io_out, io_oe;
  logic [23:0] mem_addr, base = 24'h00_0000;
  logic [7:0]  mem_wdata, mem_rdata = 8'h00, rx, d;
  logic [1:0]  erase_size, er_sz;
  logic [7:0]  mem [int];
  logic [7:0]  wq [$];
  int          fail_count, tests_run, rd_cnt, wr_cnt, er_cnt;
  sfpi_top #(.ADDR_W(ADDR_BITS)) uut (.core_clk(core_clk), .rst(rst), .cs_n(cs_n), .sck(sck), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe), .pause_n(pause_n), .quad_enable_bit(quad_enable_bit), .busy_in(busy_in),
    .standby(standby), .active(active), .wr_protect_n(wr_protect_n), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .erase_req(erase_req),
    .erase_size(erase_size));
  sfpi_host host (.core_clk(core_clk), .io_out(io_out), .io_oe(io_oe), .cs_n(cs_n), .sck(sck),
    .pause_n(pause_n), .io_in(io_in));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("tests_run %0d fail_count %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // unwritten bytes read as an address pattern
  function automatic logic [7:0] rdm(input logic [23:0] a);
    return mem.exists(a) ? mem[a] : a[7:0] ^ 8'ha5;
  endfunction
  task automatic cmd(input logic [7:0] op, input logic [23:0] a);
    host.xfer(op, 1, rx);
    if (op != CMD_ERASE_ALL)
      for (int i = 2; i >= 0; i--)
        host.xfer(a[8*i +: 8], 1, rx);
  endtask
  task automatic rd(input logic [7:0] op, input int lanes, input logic m3, input logic hold, input logic [23:0] a);
    host.sel(m3, hold);
    cmd(op, a);
    if (op != CMD_READ)
      repeat (DUMMY_CYCLES / 8) host.xfer(8'h00, 1, rx);
    for (int i = 0; i < 2; i++) begin
      host.xfer(8'h00, lanes, rx);
      check(rx, rdm(a + 24'(i)));
      check(io_oe, (lanes == 4) ? 4'hf : (lanes == 2) ? 4'h3 : 4'h2);
      if (hold && i == 0) begin
        host.sck <= 1'b0;
        host.tick(4);
        host.pause_n <= 1'b0;  // selected with sck low before the pause
        host.tick(8);
        check(io_oe, 4'h0);
        host.pause_n <= 1'b1;
        host.tick(4);
      end
    end
    host.desel();
    check({io_oe, active, standby}, 6'h01);
    $display("read %h lanes %0d done", op, lanes);
  endtask
  always @(posedge core_clk) begin
    if (mem_rd) begin
      rd_cnt <= rd_cnt + 1;
      mem_rdata <= rdm(mem_addr);
    end
    if (mem_wr) begin
      check(mem_addr, base + 24'(wr_cnt));
      check(mem_wdata, wq.pop_front());
      wr_cnt <= wr_cnt + 1;
    end
    if (erase_req) begin
      er_cnt <= er_cnt + 1;
      er_sz <= erase_size;
    end
  end
  initial forever #10 core_clk = ~core_clk;
  initial begin
    repeat (100000) @(posedge core_clk);
    fail_count++;
    summarize();
  end
  initial begin
    void'($urandom(32'hd226_815b));
    @(posedge core_clk);
    host.cs_n <= 1'b0;  // low through reset, so no select edge is seen
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    host.tick(4);
    cmd(CMD_READ, 24'h00_0000);
    host.xfer(8'h00, 1, rx);
    check(rd_cnt, 0);
    host.desel();
    host.xfer(CMD_READ, 1, rx);
    host.xfer(8'h00, 1, rx);
    host.sel(1'b0, 1'b0);
    host.xfer(CMD_READ, 2, rx);
    host.desel();
    check(rd_cnt, 0);
    $display("refused input done");
    rd(CMD_READ, 1, 1'b0, 1'b1, 24'($urandom()));
    rd(CMD_READ, 1, 1'b1, 1'b0, 24'($urandom()));
    rd(CMD_DUAL_READ, 2, 1'b1, 1'b0, 24'($urandom()));
    base = {16'($urandom()), 8'h00};
    host.sel(1'b0, 1'b0);
    cmd(CMD_PROGRAM, base);
    for (int i = 0; i <= PAGE_BYTES; i++) begin
      d = 8'($urandom());
      if (i < PAGE_BYTES) begin
        wq.push_back(d);
        mem[base + 24'(i)] = d;
      end
      host.xfer(d, 1, rx);
    end
    host.desel();
    check(wr_cnt, PAGE_BYTES);
    $display("program done");
    quad_enable_bit <= 1'b1;
    host.tick(4);
    check(wr_protect_n, 1'b1);
    rd(CMD_QUAD_READ, 4, 1'b0, 1'b0, base);
    quad_enable_bit <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      busy_in <= (i == 0);
      host.sel(1'b0, 1'b0);
      cmd(EC[i], 24'($urandom()));
      host.desel();
      check(er_cnt, i + 1);
      check(er_sz, i);
      check(standby, i != 0);
    end
    $display("erase done");
    summarize();
  end
endmodule
`default_nettype wire

// ---- sfpi_top.sv ----
// sfpi_top: pin-level serial flash device front end
// assumes: host drives sck at least ~8x slower than core_clk; array behind mem_* ports
// Contract
// - chip select high: deselected, all data outputs floated
// - deselected enters standby unless a program or erase cycle still runs
// - chip select low enables device into active power state
// - after power-up no instruction accepted before a chip select falling edge
// - input bits sampled on each rising serial clock edge
// - output bits change on falling serial clock edge
// - dual/quad reads turn serial input into output bit 0
// - serial input ignored while chip select deasserted
// - dual reads drive serial output as bit 1 with bit 0
// - works with clock mode 0 or mode 3
// - 65536 pages of 256 bytes; program takes at most 256 bytes
// - erase in 4KB, 32KB, 64KB blocks or whole chip
// - pause input ignores clock and data and floats output, keeps selection
// - quad enable bit turns write-protect pin into data bit 2
`timescale 1ns/10ps
`default_nettype none
module sfpi_top
  import sfpi_pkg::*;
#(
  parameter int ADDR_W = sfpi_pkg::ADDR_BITS
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              cs_n,
  input  wire logic              sck,
  input  wire logic [3:0]        io_in,
  output logic      [3:0]        io_out,
  output logic      [3:0]        io_oe,
  input  wire logic              pause_n,
  input  wire logic              quad_enable_bit,
  input  wire logic              busy_in,
  output logic                   standby,
  output logic                   active,
  output logic                   wr_protect_n,
  output logic                   mem_rd,
  output logic                   mem_wr,
  output logic      [ADDR_W-1:0] mem_addr,
  output logic      [7:0]        mem_wdata,
  input  wire logic [7:0]        mem_rdata,
  output logic                   erase_req,
  output logic      [1:0]        erase_size
);
  import sfpi_pkg::*;

  typedef enum logic [2:0] {SFPI_IDLE, SFPI_CMD, SFPI_ADDR, SFPI_DUMMY, SFPI_DOUT, SFPI_DIN, SFPI_DONE}
    sfpi_state_type;

  logic [3:0] io_s;
  logic       cs_n_s, sck_s, pause_n_s, qe_s;
  logic       sck_rise, sck_fall;
  logic       cs_n_r, armed_r;
  sfpi_state_type state_r, state_nxt;
  sfpi_op_type    op_r;
  sfpi_lane_type  lane_r;
  logic [7:0]  shift_r;
  logic [4:0]  cnt_r;
  logic [ADDR_W-1:0] addr_r;
  logic [7:0]  out_r;
  logic [8:0]  bytes_r;
  logic        first_fall_r;
  logic        shown_r;
  logic [1:0]  fill_r;

  // select pipeline starts low, so a pin held low through reset shows no select edge
  sfpi_sync #(.WIDTH(8), .INIT(8'h04)) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in ({io_in, quad_enable_bit, pause_n, sck, cs_n}),
    .sync_out ({io_s, qe_s, pause_n_s, sck_s, cs_n_s})
  );

  // clock and data frozen while paused or deselected
  wire edge_gate = ~cs_n_s & pause_n_s;

  sfpi_edge u_edge (
    .core_clk (core_clk),
    .rst      (rst),
    .sck_s    (sck_s),
    .gate     (edge_gate),
    .rise     (sck_rise),
    .fall     (sck_fall)
  );

  // only edges matter, so idle level of sck is irrelevant (mode 0 and 3)
  wire cs_fall = cs_n_r & ~cs_n_s;
  wire cs_rise = ~cs_n_r & cs_n_s;

  // single-lane input bit is io0 only
  wire       in_bit  = io_s[0];
  wire [7:0] shift_in = {shift_r[6:0], in_bit};

  wire [7:0] cmd_byte = shift_in;
  wire       is_dread = cmd_byte == CMD_DUAL_READ;
  wire       is_qread = (cmd_byte == CMD_QUAD_READ) & qe_s;
  sfpi_op_type cmd_op;
  assign cmd_op = (cmd_byte == CMD_READ)      ? SFPI_OP_READ  :
                  is_dread                    ? SFPI_OP_DREAD :
                  is_qread                    ? SFPI_OP_QREAD :
                  (cmd_byte == CMD_PROGRAM)   ? SFPI_OP_PROG  :
                  (cmd_byte == CMD_ERASE_4K)  ? SFPI_OP_E4K   :
                  (cmd_byte == CMD_ERASE_32K) ? SFPI_OP_E32K  :
                  (cmd_byte == CMD_ERASE_64K) ? SFPI_OP_E64K  :
                  (cmd_byte == CMD_ERASE_ALL) ? SFPI_OP_ECHIP : SFPI_OP_NONE;

  wire cmd_done  = (state_r == SFPI_CMD) & sck_rise & (cnt_r == 5'd7);
  wire addr_done = (state_r == SFPI_ADDR) & sck_rise & (cnt_r == 5'(ADDR_W - 1));
  wire dum_done  = (state_r == SFPI_DUMMY) & sck_rise & (cnt_r == 5'(DUMMY_CYCLES - 1));
  wire byte_in   = (state_r == SFPI_DIN) & sck_rise & (cnt_r == 5'd7);
  wire is_erase  = (op_r == SFPI_OP_E4K) | (op_r == SFPI_OP_E32K) | (op_r == SFPI_OP_E64K);
  wire fast_rd   = (op_r == SFPI_OP_DREAD) | (op_r == SFPI_OP_QREAD);

  // bits per falling edge and end of an output byte
  wire [4:0] out_step = (lane_r == SFPI_LANE4) ? 5'd4 : (lane_r == SFPI_LANE2) ? 5'd2 : 5'd1;
  wire       out_last = (cnt_r + out_step) >= 5'd8;
  wire       rd_next  = (state_r == SFPI_DOUT) & sck_fall & out_last;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      SFPI_IDLE:  state_nxt = state_r;
      SFPI_CMD:   if (cmd_done) begin
                    state_nxt = (cmd_op == SFPI_OP_NONE) ? SFPI_DONE :
                                (cmd_op == SFPI_OP_ECHIP) ? SFPI_DONE : SFPI_ADDR;
                  end
      SFPI_ADDR:  if (addr_done) begin
                    state_nxt = fast_rd ? SFPI_DUMMY : (op_r == SFPI_OP_READ) ? SFPI_DOUT :
                                (op_r == SFPI_OP_PROG) ? SFPI_DIN : SFPI_DONE;
                  end
      SFPI_DUMMY: if (dum_done) begin
                    state_nxt = SFPI_DOUT;
                  end
      SFPI_DOUT:  state_nxt = state_r;
      SFPI_DIN:   state_nxt = state_r;
      SFPI_DONE:  state_nxt = state_r;
    endcase
  end

  // partial frames dropped on deselect; instruction phase armed only after a select fall
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cs_n_r  <= 1'b0;
      armed_r <= 1'b0;
      state_r <= SFPI_IDLE;
      fill_r  <= 2'b00;
    end else begin
      cs_n_r <= cs_n_s;
      fill_r <= {fill_r[0], 1'b1};
      if (cs_n_s) begin
        state_r <= SFPI_IDLE;
      end else if (cs_fall) begin
        armed_r <= 1'b1;
        state_r <= SFPI_CMD;
      end else if (armed_r) begin
        state_r <= state_nxt;
      end
    end
  end

  // shifting of instruction, address and program data on rising edges
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      shift_r <= 8'h00;
      cnt_r   <= 5'd0;
      op_r    <= SFPI_OP_NONE;
      lane_r  <= SFPI_LANE1;
      addr_r  <= '0;
    end else if (cs_fall | cs_rise) begin
      cnt_r   <= 5'd0;
      shift_r <= 8'h00;
    end else if (sck_rise & (state_r != SFPI_DOUT)) begin
      shift_r <= shift_in;
      cnt_r   <= (cmd_done | addr_done | dum_done | byte_in) ? 5'd0 : cnt_r + 5'd1;
      if (cmd_done) begin
        op_r   <= cmd_op;
        lane_r <= is_qread ? SFPI_LANE4 : is_dread ? SFPI_LANE2 : SFPI_LANE1;
      end
      if (state_r == SFPI_ADDR) begin
        addr_r <= {addr_r[ADDR_W-2:0], in_bit};
      end
      if (byte_in) begin
        // wrap inside the page so one program never exceeds a page
        addr_r[7:0] <= addr_r[7:0] + 8'd1;
      end
    end else if (sck_fall & (state_r == SFPI_DOUT)) begin
      cnt_r <= out_last ? 5'd0 : cnt_r + out_step;
      if (out_last) begin
        addr_r <= addr_r + ADDR_W'(1);
      end
    end
  end

  // array requests: read fetch, program byte, erase command
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mem_rd     <= 1'b0;
      mem_wr     <= 1'b0;
      mem_addr   <= '0;
      mem_wdata  <= 8'h00;
      erase_req  <= 1'b0;
      erase_size <= 2'd0;
      bytes_r    <= 9'd0;
    end else begin
      mem_rd    <= (addr_done & (op_r == SFPI_OP_READ)) | dum_done | rd_next;
      // addr_r steps on this same edge, so the prefetch uses the stepped address
      mem_addr  <= addr_done ? {addr_r[ADDR_W-2:0], in_bit} : rd_next ? addr_r + ADDR_W'(1) : addr_r;
      mem_wr    <= byte_in & (bytes_r < 9'(PAGE_BYTES));
      mem_wdata <= shift_in;
      if (cs_fall) begin
        bytes_r <= 9'd0;
      end else if (byte_in & (bytes_r < 9'(PAGE_BYTES))) begin
        bytes_r <= bytes_r + 9'd1;
      end
      // erase issued only when a full frame closes cleanly
      erase_req <= cs_rise & (state_r == SFPI_DONE) & (is_erase | (op_r == SFPI_OP_ECHIP));
      if (cs_rise) begin
        erase_size <= (op_r == SFPI_OP_E4K)  ? 2'd0 :
                      (op_r == SFPI_OP_E32K) ? 2'd1 :
                      (op_r == SFPI_OP_E64K) ? 2'd2 : 2'd3;
      end
    end
  end

  // output shifting on falling edges, data loaded from the array
  wire dout_load = (state_r == SFPI_DOUT) & sck_fall & first_fall_r;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      out_r        <= 8'h00;
      first_fall_r <= 1'b1;
      shown_r      <= 1'b0;
    end else if (state_r != SFPI_DOUT) begin
      first_fall_r <= 1'b1;
      shown_r      <= 1'b0;
    end else if (sck_fall) begin
      // drive stays on across byte ends, so the last bit of each byte is not floated
      first_fall_r <= out_last;
      shown_r      <= 1'b1;
      out_r <= dout_load ? mem_rdata : (out_r << out_step);
    end
  end

  wire       drive_en = ~cs_n_s & pause_n_s & (state_r == SFPI_DOUT) & shown_r;
  wire [3:0] oe_nxt   = ~drive_en ? 4'h0 :
                        (lane_r == SFPI_LANE4) ? 4'hF :
                        (lane_r == SFPI_LANE2) ? 4'h3 : 4'h2;
  wire [3:0] out_nxt  = (lane_r == SFPI_LANE4) ? out_r[7:4] :
                        (lane_r == SFPI_LANE2) ? {2'b00, out_r[7:6]} : {2'b00, out_r[7], 1'b0};

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      io_out       <= 4'h0;
      io_oe        <= 4'h0;
      standby      <= 1'b0;
      active       <= 1'b0;
      wr_protect_n <= 1'b1;
    end else begin
      io_out       <= out_nxt;
      io_oe        <= oe_nxt;
      standby      <= cs_n_s & ~busy_in;
      // held low until the select pipeline carries real pin samples
      active       <= ~cs_n_s & fill_r[1];
      wr_protect_n <= qe_s ? 1'b1 : io_s[2];
    end
  end
endmodule
`default_nettype wire
